// file: verification/asrc_host_properties.sv
/*
  pin timing checks for asrc_host, bound to its ports.
  assumes one memory on the bus and a 100 MHz sys_clk.
*/
`timescale 1ns/100ps
module asrc_host_properties
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // observed ports
  input wire logic       rsp_valid,
  input wire asrc_pins_s mem_pins,
  input wire logic       mem_data_oe
);
  logic rd_on;
  assign rd_on = !mem_pins.primary_select_n && mem_pins.secondary_select
    && !mem_pins.output_enable_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_WE_HIGH: assert property (rd_on |-> mem_pins.write_n)
    else $error("write strobe low in read");
  AST_RD_ACCESS: assert property (rsp_valid |-> $past(rd_on, 6))
    else $error("read sampled before access time");
  AST_WR_PULSE: assert property (
    $fell(mem_pins.write_n) |-> !mem_pins.write_n [*2])
    else $error("write pulse too short");
  AST_WR_SELECT: assert property ($rose(mem_pins.write_n) |->
    $past(!mem_pins.primary_select_n, 3) && $past(mem_pins.addr, 3)
    == mem_pins.addr)
    else $error("select or address late before write end");
  AST_WR_RECOVER: assert property (
    $rose(mem_pins.write_n) |=> $stable(mem_pins.addr))
    else $error("address moved in write recovery");
  AST_CYCLE: assert property (
    $changed(mem_pins.addr) |=> $stable(mem_pins.addr) [*3])
    else $error("address cycle shorter than 35 ns");
  AST_NO_CLASH: assert property (mem_data_oe |-> !rd_on)
    else $error("host drives bus while memory reads");
endmodule

bind asrc_host asrc_host_properties u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
  .mem_pins(mem_pins), .mem_data_oe(mem_data_oe)
);

// file: verification/asrc_host_tb.sv
/*
  self-checking bench for asrc_host against the memory model.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
module asrc_host_tb;
  import asrc_pkg::*;
  logic       sys_clk, rst_n, req_valid, req_ready, rsp_valid, mem_data_oe;
  asrc_req_s  req;
  asrc_pins_s mem_pins;
  logic [7:0] rsp_data, mem_data_out, bus;
  int         n_errors, comparisons;
  asrc_host DUT (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .mem_pins(mem_pins), .mem_data_in(bus),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  asrc_sram_model u_mem (.pins(mem_pins), .host_data(mem_data_out),
    .host_oe(mem_data_oe), .bus(bus));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [16:0] got, want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wait_sel(input logic v);
    for (int n = 0; mem_pins.primary_select_n !== v; n++) begin
      if (n == 40) begin
        n_errors++;
        $display("unexpected at %0t: select never reached %b", $time, v);
        return;
      end
      @(posedge sys_clk);
    end
  endtask
  // one whole request; reads are judged as the select lifts
  task automatic access(input logic w, input logic [12:0] a,
                        input logic [7:0] d);
    req_valid <= 1'b1;
    req <= '{w, a, d};
    @(posedge sys_clk);
    for (int n = 0; req_ready !== 1'b1 && n < 20; n++) @(posedge sys_clk);
    check(17'(req_ready), 17'h1);
    req_valid <= 1'b0;
    wait_sel(1'b0);
    check(17'(mem_pins.secondary_select), 17'h1);
    check(17'(mem_data_oe), 17'(w));
    check(17'(mem_pins.write_n), 17'(!w));
    wait_sel(1'b1);
    if (!w) check({8'h0, rsp_valid, rsp_data}, {9'h1, d});
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic test_idle;
    check(17'(mem_pins), 17'h16000);
    check(17'(mem_data_oe), 17'h0);
    $display("test idle done");
  endtask
  task automatic test_edges;
    access(1'b1, 13'h0000, 8'h5a);
    access(1'b1, 13'h1fff, 8'ha5);
    access(1'b0, 13'h0000, 8'h5a);
    access(1'b0, 13'h1fff, 8'ha5);
    $display("test edges done");
  endtask
  task automatic test_burst;
    for (int i = 0; i < 4; i++) access(1'b1, 13'(i * 1365), 8'h11 << i);
    for (int i = 3; i >= 0; i--) access(1'b0, 13'(i * 1365), 8'h11 << i);
    $display("test burst done");
  endtask
  task automatic test_rerun;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    test_idle();
    access(1'b0, 13'h1fff, 8'ha5);
    $display("test rerun done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // whole run is near 150 cycles; cut off well beyond it
  initial begin
    #50000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    test_idle();
    test_edges();
    test_burst();
    test_rerun();
    give_verdict();
  end
endmodule

// file: verification/asrc_sram_model.sv
/*
  behavioural 8192 x 8 static memory on the far side of the host.
  assumes host data and enable arrive apart; the bus is resolved here.
*/
`timescale 1ns/100ps
module asrc_sram_model
  import asrc_pkg::*;
(
  // memory pins
  input wire asrc_pins_s       pins,
  input wire logic [7:0]       host_data,
  input wire logic             host_oe,
  // resolved bus
  output logic [7:0]           bus
);
  logic [7:0] mem [0:8191];
  logic [7:0] q;
  logic       rd_on;
  logic       wr_on;
  // mode decode, purely static
  assign wr_on = !pins.primary_select_n && pins.secondary_select
    && !pins.write_n;
  assign rd_on = !pins.primary_select_n && pins.secondary_select
    && pins.write_n && !pins.output_enable_n;
  // store what the bus holds as the write ends
  always @(negedge wr_on) mem[pins.addr] = bus;
  // old data 3 ns, garbage, then new data at the 35 ns limit
  always @(pins.addr or rd_on) begin
    q <= #3 ~q;
    q <= #35 mem[pins.addr];
  end
  // released bus shows the inverse of q, which matches the old read data from 3 ns to 35 ns after release
  assign bus = host_oe ? host_data : (rd_on ? q : ~q);
endmodule

// file: verilog/asrc_host.sv
/*
  host controller driving an 8192 x 8 asynchronous static memory.
  assumes one memory on the bus, a 100 MHz sys_clk, and a user that holds
  a request steady while req_valid is high until req_ready.
*/
`timescale 1ns/100ps
`include "asrc_map.svh"
module asrc_host
  import asrc_pkg::*;
#(
  parameter int RD_CYC  = `ASRC_RD_CYC,
  parameter int WP_CYC  = `ASRC_WP_CYC,
  parameter int WR_CYC  = `ASRC_WR_CYC,
  parameter int CYC_CYC = `ASRC_CYC_CYC
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // user request
  input  wire logic                    req_valid,
  input  wire asrc_req_s               req,
  output logic                         req_ready,
  // read answer
  output logic                         rsp_valid,
  output logic [`ASRC_DATA_W-1:0]      rsp_data,
  // memory pins
  output asrc_pins_s                   mem_pins,
  input  wire logic [`ASRC_DATA_W-1:0] mem_data_in,
  output logic [`ASRC_DATA_W-1:0]      mem_data_out,
  output logic                         mem_data_oe
);
  // control group
  asrc_state_e              state_q, state_d;
  logic [`ASRC_CNT_W-1:0]   cnt_q, cnt_d;
  logic [`ASRC_CNT_W-1:0]   span_q, span_d;
  logic                     wr_q, wr_d;
  // pin group
  asrc_pins_s               pins_q, pins_d;
  // write data group
  logic [`ASRC_DATA_W-1:0]  dout_q, dout_d;
  logic                     oe_q, oe_d;
  // answer group
  logic                     ready_q, ready_d;
  logic                     rvalid_q, rvalid_d;
  logic [`ASRC_DATA_W-1:0]  rdata_q, rdata_d;
  // data pin synchroniser
  logic [`ASRC_DATA_W-1:0]  sync1_q, sync2_q;
  // decoded events shared between the groups
  logic                     take;
  logic                     read_done;
  logic                     strobe_done;
  logic                     recover_done;

  // data pins come from outside the clock domain
  always_ff @(posedge sys_clk) begin
    sync1_q <= mem_data_in;
    sync2_q <= sync1_q;
  end

  always_comb begin
    take         = (state_q == ASRC_IDLE) && req_valid && !ready_q;
    // access time plus the synchroniser stages before the sample is trusted
    read_done    = (state_q == ASRC_READ) &&
                   (cnt_q >= 4'(RD_CYC + `ASRC_SYNC_STAGES)); // RQ6
    strobe_done  = (state_q == ASRC_WSTROBE) &&
                   (cnt_q >= 4'(WP_CYC - 1)); // RQ12
    // address held through recovery and a full cycle span
    recover_done = (state_q == ASRC_RECOVER) &&
                   (cnt_q >= 4'(WR_CYC - 1)) &&
                   (span_q >= 4'(CYC_CYC)); // RQ10 RQ9
  end

  // control: sequence, cycle counter, cycle span and transfer kind
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    // span saturates so a long idle gap never wraps under the cycle limit
    span_d  = (span_q == '1) ? span_q : span_q + 4'h1;
    case (state_q)
      ASRC_IDLE: begin
        if (take) begin
          state_d = ASRC_SETUP;
          cnt_d   = 4'h0;
          span_d  = 4'h1; // RQ9
          wr_d    = req.write;
        end
      end
      ASRC_SETUP: begin
        cnt_d = 4'h0;
        if (wr_q) begin
          state_d = ASRC_WSTROBE;
        end else begin
          state_d = ASRC_READ;
        end
      end
      ASRC_READ: begin
        cnt_d = cnt_q + 4'h1;
        if (read_done) begin
          cnt_d   = 4'h0;
          state_d = ASRC_RECOVER;
        end
      end
      ASRC_WSTROBE: begin
        cnt_d = cnt_q + 4'h1;
        if (strobe_done) begin
          cnt_d   = 4'h0;
          state_d = ASRC_RECOVER;
        end
      end
      ASRC_RECOVER: begin
        cnt_d = cnt_q + 4'h1;
        if (recover_done) begin
          state_d = ASRC_IDLE;
        end
      end
      default: begin
        state_d = ASRC_IDLE;
        cnt_d   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ASRC_IDLE;
      cnt_q   <= 4'h0;
      span_q  <= 4'h0;
      wr_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      span_q  <= span_d;
      wr_q    <= wr_d;
    end
  end

  // pins: every level changes only on a clock edge, never mid-cycle
  always_comb begin
    pins_d = pins_q;
    case (state_q)
      ASRC_IDLE: begin
        // standby while idle keeps memory in low power, bus released
        pins_d.primary_select_n = 1'b1; // RQ3
        pins_d.write_n          = 1'b1;
        pins_d.output_enable_n  = 1'b1;
        if (take) begin
          // address settles no later than select assertion
          pins_d.addr = req.addr; // RQ6
        end
      end
      ASRC_SETUP: begin
        pins_d.primary_select_n = 1'b0;
        pins_d.secondary_select = 1'b1;
        if (wr_q) begin
          // output enable stays high so memory never drives against us
          pins_d.output_enable_n = 1'b1; // RQ11
          pins_d.write_n         = 1'b0; // RQ12
        end else begin
          // strobe held high for the whole read
          pins_d.write_n         = 1'b1; // RQ5
          pins_d.output_enable_n = 1'b0; // RQ4
        end
      end
      ASRC_READ: begin
        if (read_done) begin
          pins_d.output_enable_n  = 1'b1;
          pins_d.primary_select_n = 1'b1; // RQ3
        end
      end
      ASRC_WSTROBE: begin
        if (strobe_done) begin
          // strobe ends first; select and data follow a cycle later
          pins_d.write_n = 1'b1; // RQ14
        end
      end
      ASRC_RECOVER: begin
        pins_d.primary_select_n = 1'b1;
      end
      default: begin
        pins_d.primary_select_n = 1'b1;
        pins_d.write_n          = 1'b1;
        pins_d.output_enable_n  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pins_q <= '{primary_select_n: 1'b1, secondary_select: 1'b0,
                  write_n: 1'b1, output_enable_n: 1'b1, addr: '0};
    end else begin
      pins_q <= pins_d;
    end
  end

  // write data: driven from select low until a cycle after the strobe
  always_comb begin
    dout_d = dout_q;
    oe_d   = oe_q;
    case (state_q)
      ASRC_IDLE: begin
        oe_d = 1'b0;
        if (take && req.write) begin
          dout_d = req.wdata;
        end
      end
      ASRC_SETUP: begin
        if (wr_q) begin
          oe_d = 1'b1; // RQ11
        end
      end
      ASRC_RECOVER: begin
        // data held past the strobe edge so the memory stores it cleanly
        oe_d = 1'b0; // RQ14
      end
      default: begin
        oe_d = oe_q;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dout_q <= '0;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  // answer: ready on take, read data once it has crossed the synchroniser
  always_comb begin
    ready_d  = take;
    rvalid_d = read_done;
    rdata_d  = rdata_q;
    if (read_done) begin
      rdata_d = sync2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_q  <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      ready_q  <= ready_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
    end
  end

  assign req_ready    = ready_q;
  assign rsp_valid    = rvalid_q;
  assign rsp_data     = rdata_q;
  assign mem_pins     = pins_q;
  assign mem_data_out = dout_q;
  assign mem_data_oe  = oe_q;
endmodule

// file: verilog/asrc_map.svh
/*
  constant map for the asynchronous static memory host controller.
  assumes a 100 MHz sys_clk; times in ns, counts derived from them.
*/
// Function
// RQ1 - memory holds 8192 bytes addressed by 13 bits on a shared data bus
// RQ2 - memory is static; host may hold any pin state indefinitely
// RQ3 - primary select high puts memory in standby with bus released
// RQ4 - only selected, output-enabled, reading memory drives the data bus
// RQ5 - host keeps write strobe high through every read cycle
// RQ6 - read data valid 35 ns after primary select, 15 ns after secondary
// RQ7 - memory holds old data at least 3 ns after address change
// RQ8 - select and strobe released together leave outputs high-impedance
// RQ9 - write cycle spans address change to address change, at least 35 ns
// RQ10 - host keeps address stable at least 3 ns after write ends
// RQ11 - host must not drive data while memory is in read state
// RQ12 - address and select 30 ns before write end, strobe at least 20 ns
// RQ13 - mode decode: standby, deselect, write, read, else high-impedance
// RQ14 - memory stores bus data present at the end of the write pulse
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_CLK_PERIOD_NS   10
`define ASRC_ADDR_W          13
`define ASRC_DATA_W          8
`define ASRC_WORDS           8192
`define ASRC_T_READ_ACC_NS   35
`define ASRC_T_CYCLE_NS      35
`define ASRC_T_WR_PULSE_NS   20
`define ASRC_T_ADDR_WEND_NS  30
`define ASRC_T_WR_RECOV_NS   3
`define ASRC_T_OUT_HOLD_NS   3
`define ASRC_CNT_W           4
`define ASRC_CYC_UP(t) (((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
// read: whole cycles that cover the access time; stages added in the logic
`define ASRC_RD_CYC   `ASRC_CYC_UP(`ASRC_T_READ_ACC_NS)
// flip-flops between the data pins and the read sample
`define ASRC_SYNC_STAGES 2
// strobe low long enough for both pulse width and select-to-end
`define ASRC_WP_CYC   `ASRC_CYC_UP(`ASRC_T_ADDR_WEND_NS)
`define ASRC_WR_CYC   `ASRC_CYC_UP(`ASRC_T_WR_RECOV_NS)
`define ASRC_CYC_CYC  `ASRC_CYC_UP(`ASRC_T_CYCLE_NS)
`endif

// file: verilog/asrc_pkg.sv
/*
  types for the asynchronous static memory host controller.
  assumes asrc_map.svh sits on the include path.
*/
`include "asrc_map.svh"
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_SETUP,
    ASRC_READ,
    ASRC_WSTROBE,
    ASRC_RECOVER
  } asrc_state_e;
  typedef struct packed {
    logic                      write;
    logic [`ASRC_ADDR_W-1:0]   addr;
    logic [`ASRC_DATA_W-1:0]   wdata;
  } asrc_req_s;
  typedef struct packed {
    logic                      primary_select_n;
    logic                      secondary_select;
    logic                      write_n;
    logic                      output_enable_n;
    logic [`ASRC_ADDR_W-1:0]   addr;
  } asrc_pins_s;
endpackage
